// *** dvc_pkg.sv ***
// Purpose: Shared constants and carriers for the playback gain block
// Assumes: Register addresses are page plus 8-bit offset
// Notes:   Gains are signed; register gain is 0.5 dB/LSB, applied gain 0.125 dB/LSB
package dvc_pkg;
  localparam logic [7:0] PAGE_CTL     = 8'h00;
  localparam logic [7:0] PAGE_COEF    = 8'h09;
  localparam logic [7:0] ADDR_FLAGS   = 8'h26;
  localparam logic [7:0] ADDR_PROFILE = 8'h3c;
  localparam logic [7:0] ADDR_SSTEP   = 8'h3f;
  localparam logic [7:0] ADDR_MUTE    = 8'h40;
  localparam logic [7:0] ADDR_GAIN_L  = 8'h41;
  localparam logic [7:0] ADDR_GAIN_R  = 8'h42;
  localparam logic [7:0] ADDR_DRC     = 8'h44;
  localparam logic [7:0] ADDR_PINCTL  = 8'h74;
  localparam logic [7:0] ADDR_PINRB   = 8'h75;
  localparam logic [7:0] COEF_FIRST   = 8'h0e;
  localparam logic [7:0] COEF_LAST    = 8'h19;
  localparam int         FLAG_L_BIT   = 4;
  localparam int         FLAG_R_BIT   = 0;
  localparam int         MUTE_L_BIT   = 3;
  localparam int         PIN_SRC_BIT  = 7;
  localparam int         PIN_CLK_BIT  = 6;
  localparam logic [1:0] MASTER_FROM_R = 2'h1;
  localparam logic [1:0] MASTER_FROM_L = 2'h2;
  localparam logic [1:0] SS_NORMAL    = 2'h0;
  localparam logic [1:0] SS_HALF      = 2'h1;
  localparam logic signed [11:0] APPL_MAX = 12'h0c0;
  localparam logic signed [11:0] APPL_MIN = 12'he04;
  localparam logic [6:0] PIN_KNEE     = 7'h5a;
  localparam logic [6:0] PIN_MUTE     = 7'h7f;
  localparam logic [7:0] PIN_TOP      = 8'h24;
  localparam logic [7:0] PIN_KNEE_GAIN = 8'hca;
  localparam logic [1:0] PROF_B       = 2'h1;
  localparam logic [1:0] PROF_C       = 2'h2;
  localparam logic [4:0] DLY_A        = 5'h15;
  localparam logic [4:0] DLY_B        = 5'h12;
  localparam logic [4:0] DLY_C        = 5'h0d;
  localparam int         IIR_FRAC     = 15;
  localparam int         MANT_FRAC    = 14;
  localparam logic [9:0] VOL_BIAS     = 10'h084;
  localparam logic [7:0] VOL_STEPS    = 8'h0c;
  localparam logic [3:0] VOL_Q0       = 4'hb;
  // 2^14 * 10^(r/40), r = 0..11, element 0 rightmost
  localparam logic [11:0][15:0] MANT = {16'h788f, 16'h71d0, 16'h6b72, 16'h656f, 16'h5fc2, 16'h5a67,
                                        16'h5557, 16'h5092, 16'h4c11, 16'h47cf, 16'h43cb, 16'h4000};
  // Estimation filter defaults, element 0 is the first coefficient byte (MSB of high-pass N0)
  localparam logic [11:0][7:0] COEF_RST = {8'hde, 8'h7f, 8'h11, 8'h00, 8'h11, 8'h00,
                                           8'h56, 8'h7f, 8'h55, 8'h80, 8'hab, 8'h7f};
  localparam logic [15:0] DRC_HI      = 16'h2000;
  localparam logic [15:0] DRC_LO      = 16'h0800;
  localparam logic signed [7:0] DRC_CUT_MIN   = 8'ha0;
  localparam logic signed [7:0] DRC_BOOST_MAX = 8'h30;

  typedef struct packed {
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dvc_reg_req_s;

  // smp[0] is the left channel, smp[1] the right
  typedef struct packed {
    logic [1:0][15:0] smp;
  } dvc_pair_s;

  typedef struct packed {
    logic [1:0]       ss_mode;
    logic [3:0]       mute_ctl;
    logic [1:0][7:0]  gain;
    logic [1:0]       drc_en;
    logic [7:0]       pin_ctl;
    logic [6:0]       pin_code;
    logic [1:0]       profile;
    logic [11:0][7:0] coef;
    logic [1:0][9:0]  applied;
    logic             half_tog;
    logic [7:0]       drc_off;
    logic [15:0]      hp_x1;
    logic [15:0]      hp_y1;
    logic [15:0]      lp_y1;
    logic [6:0]       sar_s1;
    logic [6:0]       sar_s2;
    logic [6:0]       sar_s3;
    logic [23:0]      div_cnt;
    logic [7:0]       rdata;
    dvc_pair_s        dout;
    logic             dout_valid;
    logic [15:0]      hp_out;
    logic [15:0]      energy;
    logic [4:0]       group_delay;
  } dvc_state_s;
endpackage

// *** dvc_gain.sv ***
// Purpose: Digital volume with soft-stepping, pin volume and compressor
// Assumes: One sample pair per sample_valid pulse, same clock domain
// Notes:   Pin code is synchronised and must read alike twice before use
// Function
// - Per-channel gain +24 to -63.5 dB
// - Applied gain steps 0.125 dB per sample
// - Soft-step field: normal, half rate, off
// - Register control default; pin after select bit
// - Four-bit mute and master gain field
// - Read-only done flags, left D4 right D0
// - Pin converter result overwrites volume setting
// - Pin-derived gain code readable, 7 bits
// - Pin converter clock source and rate
// - Pin code to gain map, 127 mutes
// - Two-bit compressor enable field
// - Compressor tracks volume output level
// - High-pass then low-pass first-order IIR
// - Six 16-bit coefficients, page 9, 14-25
// - Reset coefficients set both cutoffs
// - High-pass out forwarded, low-pass magnitude energy
// - Compressed gain uses volume and compressor
// - Profile A group delay 21 samples
// - Profile B group delay 18 samples
// - Profile C group delay 13 samples
`timescale 1ns/1ps
module dvc_gain #(
  parameter int PIN_DIV_A = 50,
  parameter int PIN_DIV_B = 500
) (
  input  logic                 ref_clk,
  input  logic                 rst_n,
  input  dvc_pkg::dvc_reg_req_s reg_req,
  output logic [7:0]           reg_rdata,
  input  logic                 sample_valid,
  input  dvc_pkg::dvc_pair_s   sample_in,
  input  logic [6:0]           volume_sense_pin,
  output dvc_pkg::dvc_pair_s   sample_out,
  output logic                 sample_out_valid,
  output logic [15:0]          hp_out,
  output logic [15:0]          energy,
  output logic [4:0]           group_delay
);
  dvc_pkg::dvc_state_s s_reg;
  dvc_pkg::dvc_state_s s_next;
  logic [23:0]         period;

  // Clip rather than wrap so a hot sample cannot flip sign
  function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
    if (v > 48'sh0000_0000_7fff)
      return 16'sh7fff;
    else if (v < 48'shffff_ffff_8000)
      return 16'sh8000;
    else
      return v[15:0];
  endfunction

  function automatic logic signed [15:0] iir(input logic signed [15:0] x, input logic signed [15:0] x1,
                                             input logic signed [15:0] y1, input logic signed [15:0] n0,
                                             input logic signed [15:0] n1, input logic signed [15:0] d1);
    logic signed [47:0] a;
    logic signed [47:0] fwd;
    logic signed [47:0] hist;
    logic signed [47:0] fb;
    // Widen before multiplying; a 16-bit product would wrap
    fwd  = 48'(n0) * 48'(x);
    hist = 48'(n1) * 48'(x1);
    fb   = 48'(d1) * 48'(y1);
    a    = fwd + hist + fb;
    return sat16(a >>> dvc_pkg::IIR_FRAC);
  endfunction

  // Gain in 0.125 dB: quantised to 0.5 dB, split into 6 dB shifts and a mantissa
  function automatic logic signed [15:0] vol(input logic signed [15:0] x, input logic signed [9:0] appl);
    logic [7:0]         idx;
    logic [3:0]         q;
    logic [3:0]         r;
    logic signed [47:0] p;
    idx = 8'((appl >>> 2) + $signed(dvc_pkg::VOL_BIAS));
    q   = 4'(idx / dvc_pkg::VOL_STEPS);
    r   = 4'(idx - 8'(q) * dvc_pkg::VOL_STEPS);
    // Zero bit keeps the unsigned mantissa positive in the signed product
    p   = 48'(x) * 48'($signed({1'b0, dvc_pkg::MANT[r]}));
    if (q >= dvc_pkg::VOL_Q0)
      p = p <<< (q - dvc_pkg::VOL_Q0);
    else
      p = p >>> (dvc_pkg::VOL_Q0 - q);
    return sat16(p >>> dvc_pkg::MANT_FRAC);
  endfunction

  // Two slopes: half-dB codes up to the knee, whole-dB beyond
  function automatic logic [7:0] pin_map(input logic [6:0] code);
    if (code <= dvc_pkg::PIN_KNEE)
      return dvc_pkg::PIN_TOP - {1'b0, code};
    else
      return dvc_pkg::PIN_KNEE_GAIN - {code - dvc_pkg::PIN_KNEE, 1'b0};
  endfunction

  // Coefficient k: high byte first, low byte second
  function automatic logic signed [15:0] coefw(input logic [11:0][7:0] c, input int k);
    return {c[2*k], c[2*k+1]};
  endfunction

  assign period = (s_reg.pin_ctl[dvc_pkg::PIN_CLK_BIT] ? 24'(PIN_DIV_B) : 24'(PIN_DIV_A))
                  << s_reg.pin_ctl[2:0];

  always_comb begin
    logic                     tick;
    logic                     pin_mode;
    logic signed [11:0]       tgt;
    logic [1:0]               done;
    logic [1:0][9:0]          tgt_q;
    logic                     step_ok;
    logic signed [15:0]       hp;
    logic signed [15:0]       lp;
    logic [7:0]               gsel;
    tick     = 1'b0;
    pin_mode = s_reg.pin_ctl[dvc_pkg::PIN_SRC_BIT];
    tgt      = '0;
    done     = '0;
    tgt_q    = '0;
    step_ok  = 1'b0;
    hp       = '0;
    lp       = '0;
    gsel     = '0;
    s_next   = s_reg;
    s_next.dout_valid = 1'b0;

    // Host register writes; read-only locations ignore writes
    if (reg_req.wr && reg_req.page == dvc_pkg::PAGE_CTL) begin
      unique case (reg_req.addr)
        dvc_pkg::ADDR_SSTEP:   s_next.ss_mode = reg_req.wdata[1:0];
        dvc_pkg::ADDR_MUTE:    s_next.mute_ctl = reg_req.wdata[3:0];
        dvc_pkg::ADDR_GAIN_L:  s_next.gain[0] = reg_req.wdata;
        dvc_pkg::ADDR_GAIN_R:  s_next.gain[1] = reg_req.wdata;
        dvc_pkg::ADDR_DRC:     s_next.drc_en = reg_req.wdata[6:5];
        dvc_pkg::ADDR_PINCTL:  s_next.pin_ctl = reg_req.wdata;
        dvc_pkg::ADDR_PROFILE: s_next.profile = reg_req.wdata[1:0];
        default: ;
      endcase
    end

    // coefficient bytes
    // Stay writable while running; no double buffering here
    if (reg_req.wr && reg_req.page == dvc_pkg::PAGE_COEF &&
        reg_req.addr >= dvc_pkg::COEF_FIRST && reg_req.addr <= dvc_pkg::COEF_LAST)
      s_next.coef[4'(reg_req.addr - dvc_pkg::COEF_FIRST)] = reg_req.wdata;

    // Pin sampling, two-stage synchroniser
    s_next.sar_s1 = volume_sense_pin;
    s_next.sar_s2 = s_reg.sar_s1;
    // Third stage only confirms the code held still for a cycle
    s_next.sar_s3 = s_reg.sar_s2;
    // Divider wraps on a tick; a rate change applies to the count in progress
    if (s_reg.div_cnt >= period - 24'h000001) begin
      s_next.div_cnt = '0;
      tick = 1'b1;
    end else begin
      s_next.div_cnt = s_reg.div_cnt + 24'h000001;
    end

    // pin result overwrites both gains
    // Assigned after host writes, so the pin wins a tie
    if (tick && pin_mode && s_reg.sar_s2 == s_reg.sar_s3) begin
      s_next.pin_code = s_reg.sar_s2;
      s_next.gain[0]  = pin_map(s_reg.sar_s2);
      s_next.gain[1]  = pin_map(s_reg.sar_s2);
    end

    // Effective target per channel
    for (int c = 0; c < 2; c++) begin
      gsel = s_reg.gain[c];
      if (c == 0 && s_reg.mute_ctl[1:0] == dvc_pkg::MASTER_FROM_R)
        gsel = s_reg.gain[1];
      if (c == 1 && s_reg.mute_ctl[1:0] == dvc_pkg::MASTER_FROM_L)
        gsel = s_reg.gain[0];
      tgt = 12'($signed(gsel)) <<< 2;
      if (s_reg.drc_en[1-c])
        tgt = tgt + 12'($signed(s_reg.drc_off));
      // gain range
      // Clamp after the offset so compression stays in range
      if (tgt > dvc_pkg::APPL_MAX)
        tgt = dvc_pkg::APPL_MAX;
      if (tgt < dvc_pkg::APPL_MIN)
        tgt = dvc_pkg::APPL_MIN;
      tgt_q[c] = tgt[9:0];
      done[c] = (s_reg.applied[c] == tgt_q[c]);
    end

    if (sample_valid) begin
      // Toggles in every mode so half rate keeps one phase
      s_next.half_tog = ~s_reg.half_tog;
      step_ok = (s_reg.ss_mode == dvc_pkg::SS_NORMAL) ||
                (s_reg.ss_mode == dvc_pkg::SS_HALF && s_reg.half_tog);
      for (int c = 0; c < 2; c++) begin
        if (s_reg.ss_mode != dvc_pkg::SS_NORMAL && s_reg.ss_mode != dvc_pkg::SS_HALF)
          s_next.applied[c] = tgt_q[c];
        else if (step_ok && $signed(s_reg.applied[c]) < $signed(tgt_q[c]))
          s_next.applied[c] = s_reg.applied[c] + 10'h001;
        else if (step_ok && $signed(s_reg.applied[c]) > $signed(tgt_q[c]))
          s_next.applied[c] = s_reg.applied[c] - 10'h001;
        // mutes
        // Muted channels keep ramping so unmute lands on target
        if (s_reg.mute_ctl[dvc_pkg::MUTE_L_BIT-c] || (pin_mode && s_reg.pin_code == dvc_pkg::PIN_MUTE))
          s_next.dout.smp[c] = '0;
        else
          s_next.dout.smp[c] = vol(sample_in.smp[c], s_reg.applied[c]);
      end
      s_next.dout_valid = 1'b1;

      // estimate on volume output, high-pass then low-pass
      hp = iir(s_reg.dout.smp[0], s_reg.hp_x1, s_reg.hp_y1,
               coefw(s_reg.coef, 0), coefw(s_reg.coef, 1), coefw(s_reg.coef, 2));
      // Low-pass history input is the previous high-pass result
      lp = iir(hp, s_reg.hp_y1, s_reg.lp_y1,
               coefw(s_reg.coef, 3), coefw(s_reg.coef, 4), coefw(s_reg.coef, 5));
      s_next.hp_x1  = s_reg.dout.smp[0];
      s_next.hp_y1  = hp;
      s_next.lp_y1  = lp;
      s_next.hp_out = hp;
      // Full-scale negative becomes 0x8000 as an unsigned magnitude
      s_next.energy = lp[15] ? 16'(-lp) : lp;

      // cut on peaks, boost when quiet
      // Offset clears while both enables are off, so re-enabling starts at unity
      if (s_reg.drc_en == 2'h0)
        s_next.drc_off = '0;
      else if (s_reg.energy > dvc_pkg::DRC_HI && $signed(s_reg.drc_off) > dvc_pkg::DRC_CUT_MIN)
        s_next.drc_off = s_reg.drc_off - 8'h01;
      else if (s_reg.energy < dvc_pkg::DRC_LO && $signed(s_reg.drc_off) < dvc_pkg::DRC_BOOST_MAX)
        s_next.drc_off = s_reg.drc_off + 8'h01;
    end

    unique case (s_reg.profile)
      dvc_pkg::PROF_B: s_next.group_delay = dvc_pkg::DLY_B;
      dvc_pkg::PROF_C: s_next.group_delay = dvc_pkg::DLY_C;
      default:         s_next.group_delay = dvc_pkg::DLY_A;
    endcase

    // Register reads; unmapped read as zero
    if (reg_req.rd) begin
      s_next.rdata = '0;
      if (reg_req.page == dvc_pkg::PAGE_CTL) begin
        unique case (reg_req.addr)
          dvc_pkg::ADDR_FLAGS: begin
            // done flags
            // Formed from current state, so a read cannot race a step
            s_next.rdata[dvc_pkg::FLAG_L_BIT] = done[0];
            s_next.rdata[dvc_pkg::FLAG_R_BIT] = done[1];
          end
          dvc_pkg::ADDR_SSTEP:   s_next.rdata = {6'h00, s_reg.ss_mode};
          dvc_pkg::ADDR_MUTE:    s_next.rdata = {4'h0, s_reg.mute_ctl};
          dvc_pkg::ADDR_GAIN_L:  s_next.rdata = s_reg.gain[0];
          dvc_pkg::ADDR_GAIN_R:  s_next.rdata = s_reg.gain[1];
          dvc_pkg::ADDR_DRC:     s_next.rdata = {1'b0, s_reg.drc_en, 5'h00};
          dvc_pkg::ADDR_PINCTL:  s_next.rdata = s_reg.pin_ctl;
          dvc_pkg::ADDR_PINRB:   s_next.rdata = {1'b0, s_reg.pin_code};
          dvc_pkg::ADDR_PROFILE: s_next.rdata = {6'h00, s_reg.profile};
          default: ;
        endcase
      end else if (reg_req.page == dvc_pkg::PAGE_COEF &&
                   reg_req.addr >= dvc_pkg::COEF_FIRST && reg_req.addr <= dvc_pkg::COEF_LAST) begin
        s_next.rdata = s_reg.coef[4'(reg_req.addr - dvc_pkg::COEF_FIRST)];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      // Unity gains, register control and normal stepping
      s_reg <= '0;
      s_reg.coef <= dvc_pkg::COEF_RST;
      s_reg.group_delay <= dvc_pkg::DLY_A;
    end else begin
      s_reg <= s_next;
    end
  end

  // Every output is a field of the registered state
  assign reg_rdata        = s_reg.rdata;
  assign sample_out       = s_reg.dout;
  assign sample_out_valid = s_reg.dout_valid;
  assign hp_out           = s_reg.hp_out;
  assign energy           = s_reg.energy;
  assign group_delay      = s_reg.group_delay;
endmodule

// *** dvc_gain_properties.sv ***
// Purpose: Port-level checks for the playback gain block
// Assumes: Synchronous active-low reset on ref_clk
// Notes:   Bound to every dvc_gain instance
`timescale 1ns/1ps
module dvc_gain_chk (
  input logic                  ref_clk,
  input logic                  rst_n,
  input dvc_pkg::dvc_reg_req_s reg_req,
  input logic [7:0]            reg_rdata,
  input logic                  sample_valid,
  input dvc_pkg::dvc_pair_s    sample_in,
  input dvc_pkg::dvc_pair_s    sample_out,
  input logic                  sample_out_valid,
  input logic [15:0]           hp_out,
  input logic [15:0]           energy,
  input logic [4:0]            group_delay
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic rf;
  logic wp;
  assign rf = reg_req.rd && reg_req.page == 8'h00 && reg_req.addr == 8'h26;
  assign wp = reg_req.wr && reg_req.page == 8'h00 && reg_req.addr == 8'h3c;
  a_valid_follow: assert property (sample_valid |=> sample_out_valid)
    else $error("output valid missing");
  a_valid_only: assert property (!sample_valid |=> !sample_out_valid)
    else $error("output valid without sample");
  a_zero_in: assert property (sample_valid && sample_in == '0 |=> sample_out == '0)
    else $error("silent input gave output");
  a_out_hold: assert property (!sample_valid |=> $stable(sample_out) && $stable(hp_out) && $stable(energy))
    else $error("outputs moved between samples");
  a_flag_bits: assert property (rf |=> (reg_rdata & 8'hee) == 8'h00)
    else $error("flag register has stray bits");
  a_rdata_hold: assert property (!reg_req.rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  a_delay_legal: assert property (group_delay inside {5'h15, 5'h12, 5'h0d})
    else $error("group delay not a profile value");
  a_delay_c: assert property (wp && reg_req.wdata[1:0] == 2'h2 |-> ##[1:3] group_delay == 5'h0d)
    else $error("profile C delay not shown");
  a_reset_delay: assert property ($rose(rst_n) |-> group_delay == 5'h15)
    else $error("reset profile delay wrong");
endmodule
bind dvc_gain dvc_gain_chk chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .sample_valid(sample_valid), .sample_in(sample_in), .sample_out(sample_out),
  .sample_out_valid(sample_out_valid), .hp_out(hp_out), .energy(energy), .group_delay(group_delay));

// *** dvc_host_model.sv ***
// Purpose: Host processor model driving registers and samples
// Assumes: Requests change only on the falling edge
// Notes:   Released fields are inverted so stale values never match
`timescale 1ns/1ps
module dvc_host_model (
  input  logic                  ref_clk,
  output dvc_pkg::dvc_reg_req_s reg_req,
  input  logic [7:0]            reg_rdata,
  output logic                  sample_valid,
  output dvc_pkg::dvc_pair_s    sample_in
);
  initial begin
    reg_req = '0;
    sample_valid = 1'b0;
    sample_in = '0;
  end
  task automatic access(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] d, input logic w,
                        output logic [7:0] q);
    @(negedge ref_clk);
    reg_req = '{pg, ad, d, w, !w};
    @(negedge ref_clk);
    reg_req = '{~pg, ~ad, ~d, 1'b0, 1'b0};
    q = reg_rdata;
  endtask
  task automatic send(input logic [15:0] l, input logic [15:0] r);
    @(negedge ref_clk);
    sample_valid = 1'b1;
    sample_in.smp = {r, l};
    @(negedge ref_clk);
    sample_valid = 1'b0;
    sample_in = ~sample_in;
  endtask
  task automatic settle(output logic [7:0] f);
    for (int i = 0; i < 200; i++) begin
      access(8'h00, 8'h26, 8'h00, 1'b0, f);
      if (f === 8'h11) return;
      send(16'h0000, 16'h0000);
    end
  endtask
endmodule

// *** testbench.sv ***
// Purpose: Self-checking bench for the playback gain block
// Assumes: Host model launches every request on the falling edge
// Notes:   Pin dividers shortened; an integer model tracks soft-stepping
`timescale 1ns/1ps
module testbench;
  logic                  ref_clk;
  logic                  rst_n;
  dvc_pkg::dvc_reg_req_s reg_req;
  logic [7:0]            reg_rdata;
  logic                  sample_valid;
  dvc_pkg::dvc_pair_s    sample_in;
  logic [6:0]            volume_sense_pin;
  dvc_pkg::dvc_pair_s    sample_out;
  logic                  sample_out_valid;
  logic [15:0]           hp_out;
  logic [15:0]           energy;
  logic [4:0]            group_delay;
  logic [7:0]            rv;
  logic [15:0]           s;
  int                    bad_count, comparisons, seed, ss, n;
  int                    tgt[2], app[2];
  int                    hx1, hy1, ly1, prv;
  logic [7:0]            cf[12];
  logic [6:0]            codes[4] = '{7'h00, 7'h5a, 7'h5b, 7'h7e};
  logic [4:0]            dly[4] = '{5'h15, 5'h12, 5'h0d, 5'h15};
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  dvc_gain #(.PIN_DIV_A(4), .PIN_DIV_B(8)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample_in(sample_in), .volume_sense_pin(volume_sense_pin),
    .sample_out(sample_out), .sample_out_valid(sample_out_valid), .hp_out(hp_out), .energy(energy),
    .group_delay(group_delay));
  dvc_host_model host_u (.ref_clk(ref_clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .sample_in(sample_in));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] ex);
    host_u.access(pg, ad, 8'h00, 1'b0, rv);
    chk("register", {24'h0, ex}, {24'h0, rv});
  endtask
  task automatic w(input logic [7:0] ad, input logic [7:0] d);
    host_u.access(8'h00, ad, d, 1'b1, rv);
    if (ad == 8'h41) tgt[0] = 4 * int'($signed(d));
    if (ad == 8'h42) tgt[1] = 4 * int'($signed(d));
    if (ad == 8'h3f) ss = int'(d);
  endtask
  // Model steps one eighth dB per sample, none at half rate
  task automatic step(input int k);
    repeat (k) begin
      host_u.send(16'h0100, 16'h0100);
      for (int c = 0; c < 2; c++)
        if (ss > 1) app[c] = tgt[c];
        else if (ss == 0 && app[c] != tgt[c]) app[c] += (tgt[c] > app[c]) ? 1 : -1;
    end
  endtask
  function automatic logic [7:0] pmap(input logic [6:0] c);
    return (c <= 7'h5a) ? 8'h24 - 8'(c) : 8'h7e - 8'(c) - 8'(c);
  endfunction
  // First-order section: (n0*x + n1*x1 + d1*y1) / 2^15, clipped to 16 bits
  function automatic int iirm(input int x, input int x1, input int y1, input int n0, input int n1, input int d1);
    longint a;
    a = longint'(n0) * x + longint'(n1) * x1 + longint'(d1) * y1;
    a = a >>> 15;
    return (a > 32767) ? 32767 : (a < -32768) ? -32768 : int'(a);
  endfunction
  function automatic int cw(input int k);
    return int'($signed({cf[2 * k], cf[2 * k + 1]}));
  endfunction
  // Estimator model: previous left output through high-pass then low-pass
  task automatic est(input int x);
    int hm;
    int lm;
    hm  = iirm(prv, hx1, hy1, cw(0), cw(1), cw(2));
    lm  = iirm(hm, hy1, ly1, cw(3), cw(4), cw(5));
    hx1 = prv;
    hy1 = hm;
    ly1 = lm;
    prv = x;
    chk("high-pass", 32'(hm), 32'($signed(hp_out)));
    chk("energy", 32'((lm < 0) ? -lm : lm), {16'h0, energy});
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    summarize();
  end
  initial begin
    seed = 44;
    rst_n = 1'b0;
    volume_sense_pin = 7'h0a;
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 12; i++) rchk(8'h09, 8'h0e + 8'(i), dvc_pkg::COEF_RST[i]);
    for (int i = 0; i < 12; i++) cf[i] = dvc_pkg::COEF_RST[i];
    rchk(8'h00, 8'h42, 8'h00);
    rchk(8'h00, 8'h26, 8'h11);
    rchk(8'h00, 8'h50, 8'h00);
    s = 16'($random(seed));
    host_u.access(8'h09, 8'h11, s[7:0], 1'b1, rv);
    cf[3] = s[7:0];
    rchk(8'h09, 8'h11, s[7:0]);
    repeat (8) begin
      s = 16'($random(seed));
      host_u.send(s, ~s);
      chk("samples", {~s, s}, sample_out);
      est(int'($signed(s)));
    end
    for (int j = 0; j < 2; j++) begin
      w(8'h41, j == 0 ? 8'h02 : 8'hfe);
      for (int k = 0; k <= 8 * (j + 1); k++) begin
        host_u.access(8'h00, 8'h26, 8'h00, 1'b0, rv);
        chk("flags", {3'h0, app[0] == tgt[0], 3'h0, app[1] == tgt[1]}, rv);
        step(1);
      end
    end
    w(8'h3f, 8'h02);
    w(8'h41, 8'h30);
    step(1);
    rchk(8'h00, 8'h26, 8'h11);
    rchk(8'h00, 8'h41, 8'h30);
    w(8'h3f, 8'h01);
    w(8'h41, 8'h2e);
    n = 0;
    rv = 8'h00;
    while (rv[4] !== 1'b1 && n < 40) begin
      step(1);
      n++;
      host_u.access(8'h00, 8'h26, 8'h00, 1'b0, rv);
    end
    chk("half rate", 32'h1, {31'h0, n inside {15, 16}});
    w(8'h3f, 8'h02);
    w(8'h41, 8'h00);
    w(8'h40, 8'h08);
    step(2);
    chk("mute", {16'h0100, 16'h0000}, sample_out);
    w(8'h42, 8'h81);
    w(8'h40, 8'h01);
    step(2);
    chk("master", 32'h0, sample_out);
    w(8'h40, 8'h02);
    step(2);
    chk("master", {16'h0100, 16'h0100}, sample_out);
    w(8'h42, 8'h00);
    w(8'h40, 8'h00);
    for (int i = 0; i < 4; i++) begin
      w(8'h3c, 8'(i));
      repeat (3) @(negedge ref_clk);
      chk("delay", {27'h0, dly[i]}, {27'h0, group_delay});
    end
    w(8'h74, 8'hc1);
    for (int i = 0; i < 4; i++) begin
      volume_sense_pin = codes[i];
      repeat (40) @(negedge ref_clk);
      rchk(8'h00, 8'h41, pmap(codes[i]));
      rchk(8'h00, 8'h42, pmap(codes[i]));
    end
    volume_sense_pin = 7'h7f;
    repeat (40) @(negedge ref_clk);
    step(2);
    chk("pin mute", 32'h0, sample_out);
    w(8'h74, 8'h00);
    w(8'h41, 8'h00);
    w(8'h42, 8'h00);
    w(8'h44, 8'h60);
    repeat (60) host_u.send(16'h0400, 16'h0400);
    chk("boost", 32'h1, {31'h0, $signed(sample_out.smp[0]) > 16'sh0400});
    w(8'h44, 8'h00);
    host_u.settle(rv);
    chk("settled", 32'h11, {24'h0, rv});
    summarize();
  end
endmodule
